//--- design/aitl_pkg.sv
package aitl_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DATA_W  = 32;
    localparam int OP_W    = 3;
    localparam int FORM_W  = 5;
    localparam int TGT_W   = 2;
    localparam int WAIT_W  = 4;
    localparam int SHORT_W = 2;
    localparam int LEN_W   = 3;
    localparam int CNT_W   = 8;

    // ----------------------------------------
    // Operations, operand forms, targets
    // ----------------------------------------
    typedef enum logic [OP_W-1:0] {
        OP_ADD  = 3'b000,
        OP_SUB  = 3'b001,
        OP_ADD_WITH_CARRY = 3'b010,
        OP_SUB_WITH_BORROW = 3'b011,
        OP_INC  = 3'b100,
        OP_DEC  = 3'b101,
        OP_CMP  = 3'b110
    } aitl_op_e;

    typedef enum logic [FORM_W-1:0] {
        F_A_RN       = 5'b00000, // accumulator, bank_byte_reg
        F_A_DIRECT_ADDR_8     = 5'b00001, // accumulator, direct_addr_8
        F_A_ATRI     = 5'b00010, // accumulator, at pointer_byte_reg
        F_A_IMM      = 5'b00011, // accumulator, 8-bit immediate
        F_RR_B       = 5'b00100, // file_byte_reg pair
        F_RR_W       = 5'b00101, // file_word_reg pair
        F_RR_D       = 5'b00110, // file_dword_reg pair
        F_R_IMM8     = 5'b00111,
        F_W_IMM16    = 5'b01000,
        F_D_IMM0     = 5'b01001, // zero_ext_imm16
        F_D_IMM1     = 5'b01010, // one_ext_imm16
        F_R_DIRECT_ADDR_8     = 5'b01011,
        F_W_DIRECT_ADDR_8     = 5'b01100,
        F_R_DIRECT_ADDR_16    = 5'b01101, // direct_addr_16
        F_W_DIRECT_ADDR_16    = 5'b01110,
        F_R_ATWR     = 5'b01111, // 64K indirect via word pointer
        F_R_ATDR     = 5'b10000, // 16M indirect via dword pointer
        F_INC_A      = 5'b10001,
        F_INC_RN     = 5'b10010,
        F_INC_DIRECT_ADDR_8   = 5'b10011,
        F_INC_ATRI   = 5'b10100,
        F_INC_R_SHT  = 5'b10101,
        F_INC_W_SHT  = 5'b10110,
        F_INC_D_SHT  = 5'b10111,
        F_INC_DATA_POINTER_REG   = 5'b11000  // data_pointer_reg by one
    } aitl_form_e;

    typedef enum logic [TGT_W-1:0] {
        TGT_INT = 2'b00, // on-chip, no penalty
        TGT_IO  = 2'b01, // I/O port
        TGT_SFR = 2'b10, // peripheral special function register
        TGT_EXT = 2'b11  // external memory
    } aitl_tgt_e;

    typedef enum logic [1:0] {
        WID_B = 2'b00,
        WID_W = 2'b01,
        WID_D = 2'b10
    } aitl_wid_e;

    typedef struct packed {
        logic [LEN_W-1:0] bin_len;
        logic [LEN_W-1:0] bin_st;
        logic [LEN_W-1:0] src_len;
        logic [LEN_W-1:0] src_st;
    } aitl_cost_s;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [SHORT_W-1:0] SHORT_CODE_1 = 2'h0;
    localparam logic [SHORT_W-1:0] SHORT_CODE_2 = 2'h1;
    localparam logic [SHORT_W-1:0] SHORT_CODE_4 = 2'h2;
    localparam logic [DATA_W-1:0]  VAL_ONE      = 32'h0000_0001;
    localparam logic [DATA_W-1:0]  VAL_TWO      = 32'h0000_0002;
    localparam logic [DATA_W-1:0]  VAL_FOUR     = 32'h0000_0004;
    localparam logic [15:0]        HI_ZEROS     = 16'h0000;
    localparam logic [15:0]        HI_ONES      = 16'hFFFF;
    localparam logic [CNT_W-1:0]   PEN_IO_DIR   = 8'h01;
    localparam logic [CNT_W-1:0]   PEN_SFR_DIR  = 8'h02;
    localparam logic [CNT_W-1:0]   PEN_IO_INC   = 8'h02;
    localparam logic [CNT_W-1:0]   PEN_SFR_INC  = 8'h03;
    localparam logic [CNT_W-1:0]   EXT_BASE     = 8'h02;
    localparam logic [CNT_W-1:0]   DEC_D_EXTRA  = 8'h01;
    localparam logic [CNT_W-1:0]   CNT_ONE      = 8'h01;
    localparam logic [CNT_W-1:0]   CNT_ZERO     = 8'h00;

    // ----------------------------------------
    // Base lengths and states per form
    // ----------------------------------------
    function automatic aitl_cost_s aitl_base_cost(input aitl_form_e f);
        case (f)
            F_A_RN:      return '{3'h1, 3'h1, 3'h2, 3'h2};
            F_A_DIRECT_ADDR_8:    return '{3'h2, 3'h1, 3'h2, 3'h1};
            F_A_ATRI:    return '{3'h1, 3'h2, 3'h2, 3'h3};
            F_A_IMM:     return '{3'h2, 3'h1, 3'h2, 3'h1};
            F_RR_B:      return '{3'h3, 3'h2, 3'h2, 3'h1};
            F_RR_W:      return '{3'h3, 3'h3, 3'h2, 3'h2};
            F_RR_D:      return '{3'h3, 3'h5, 3'h2, 3'h4};
            F_R_IMM8:    return '{3'h4, 3'h3, 3'h3, 3'h2};
            F_W_IMM16:   return '{3'h5, 3'h4, 3'h4, 3'h3};
            F_D_IMM0:    return '{3'h5, 3'h6, 3'h4, 3'h5};
            F_D_IMM1:    return '{3'h5, 3'h6, 3'h4, 3'h5};
            F_R_DIRECT_ADDR_8:    return '{3'h4, 3'h3, 3'h3, 3'h2};
            F_W_DIRECT_ADDR_8:    return '{3'h4, 3'h4, 3'h3, 3'h3};
            F_R_DIRECT_ADDR_16:   return '{3'h5, 3'h3, 3'h4, 3'h2};
            F_W_DIRECT_ADDR_16:   return '{3'h5, 3'h4, 3'h4, 3'h3};
            F_R_ATWR:    return '{3'h4, 3'h3, 3'h3, 3'h2};
            F_R_ATDR:    return '{3'h4, 3'h4, 3'h3, 3'h3};
            F_INC_A:     return '{3'h1, 3'h1, 3'h1, 3'h1};
            F_INC_RN:    return '{3'h1, 3'h1, 3'h2, 3'h2};
            F_INC_DIRECT_ADDR_8:  return '{3'h2, 3'h2, 3'h2, 3'h2};
            F_INC_ATRI:  return '{3'h1, 3'h3, 3'h2, 3'h4};
            F_INC_R_SHT: return '{3'h3, 3'h2, 3'h2, 3'h1};
            F_INC_W_SHT: return '{3'h3, 3'h2, 3'h2, 3'h1};
            F_INC_D_SHT: return '{3'h3, 3'h4, 3'h2, 3'h3};
            F_INC_DATA_POINTER_REG:  return '{3'h1, 3'h1, 3'h1, 3'h1};
            default:     return '0;
        endcase
    endfunction

endpackage

//--- design/aitl_alu_if.sv
`timescale 1ns/1ps
// Operands in, result and flags out of the arithmetic unit
interface aitl_alu_if;
    import aitl_pkg::*;
    aitl_op_e          op;
    aitl_wid_e         wid;
    logic [DATA_W-1:0] dest;
    logic [DATA_W-1:0] src;
    logic              cin;
    logic [DATA_W-1:0] res;
    logic              cout;
    logic              zero;
    logic              neg;
    logic              ovf;
    logic              wr;

    modport core (output op, wid, dest, src, cin,
                  input  res, cout, zero, neg, ovf, wr);
    modport alu  (input  op, wid, dest, src, cin,
                  output res, cout, zero, neg, ovf, wr);
endinterface

//--- design/aitl_alu.sv
`timescale 1ns/1ps
module aitl_alu
    import aitl_pkg::*;
(
    aitl_alu_if.alu bus
);

    // ----------------------------------------
    // Width helpers
    // ----------------------------------------
    function automatic logic [DATA_W-1:0] wmask(input logic [DATA_W-1:0] v,
                                                input aitl_wid_e w);
        case (w)
            WID_B:   return {24'h00_0000, v[7:0]};
            WID_W:   return {HI_ZEROS, v[15:0]};
            default: return v;
        endcase
    endfunction

    function automatic logic msb(input logic [DATA_W:0] v,
                                 input aitl_wid_e w);
        case (w)
            WID_B:   return v[7];
            WID_W:   return v[15];
            default: return v[31];
        endcase
    endfunction

    function automatic logic cbit(input logic [DATA_W:0] v,
                                  input aitl_wid_e w);
        case (w)
            WID_B:   return v[8];
            WID_W:   return v[16];
            default: return v[32];
        endcase
    endfunction

    // ----------------------------------------
    // Add / subtract datapath
    // ----------------------------------------
    always_comb begin
        logic [DATA_W:0] a;
        logic [DATA_W:0] b;
        logic [DATA_W:0] c;
        logic [DATA_W:0] r;
        logic            sub;
        a   = {1'b0, wmask(bus.dest, bus.wid)};
        b   = {1'b0, wmask(bus.src, bus.wid)};
        c   = '0;
        sub = (bus.op == OP_SUB) || (bus.op == OP_SUB_WITH_BORROW) ||
              (bus.op == OP_DEC) || (bus.op == OP_CMP);
        if (bus.op == OP_ADD_WITH_CARRY || bus.op == OP_SUB_WITH_BORROW) begin
            c = (DATA_W+1)'(bus.cin);
        end
        r = sub ? (a - b - c) : (a + b + c);
        bus.res  = wmask(r[DATA_W-1:0], bus.wid);
        bus.cout = cbit(r, bus.wid);
        bus.neg  = msb(r, bus.wid);
        bus.zero = (wmask(r[DATA_W-1:0], bus.wid) == '0);
        bus.ovf  = sub ?
            ((msb(a, bus.wid) != msb(b, bus.wid)) &&
             (msb(r, bus.wid) != msb(a, bus.wid))) :
            ((msb(a, bus.wid) == msb(b, bus.wid)) &&
             (msb(r, bus.wid) != msb(a, bus.wid)));
        bus.wr   = (bus.op != OP_CMP);
    end

endmodule

//--- design/aitl_core.sv
`timescale 1ns/1ps
module aitl_core
    import aitl_pkg::*;
(
    input  wire logic              REF_CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic              START_I,
    input  wire logic [OP_W-1:0]   OP_I,
    input  wire logic [FORM_W-1:0] FORM_I,
    input  wire logic              SRC_MODE_I,
    input  wire logic [TGT_W-1:0]  TARGET_I,
    input  wire logic [WAIT_W-1:0] WAIT_N_I,
    input  wire logic [SHORT_W-1:0] SHORT_I,
    input  wire logic              CARRY_I,
    input  wire logic [DATA_W-1:0] DEST_I,
    input  wire logic [DATA_W-1:0] SRC_I,
    output logic                   BUSY_O,
    output logic                   DONE_O,
    output logic                   ILLEGAL_O,
    output logic [LEN_W-1:0]       LEN_O,
    output logic [CNT_W-1:0]       STATES_O,
    output logic [DATA_W-1:0]      RESULT_O,
    output logic                   CARRY_O,
    output logic                   ZERO_O,
    output logic                   NEG_O,
    output logic                   OVF_O,
    output logic                   WRITE_O
);

    // ----------------------------------------
    // Types and declarations
    // ----------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } aitl_fsm_e;

    aitl_alu_if alu_bus ();

    aitl_op_e          op;
    aitl_form_e        form;
    aitl_tgt_e         tgt;
    aitl_cost_s        cost;
    logic              legal;
    logic [LEN_W-1:0]  len_sel;
    logic [CNT_W-1:0]  total_st;
    logic [DATA_W-1:0] src_opnd;

    aitl_fsm_e         state_r;
    aitl_fsm_e         state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              busy_r;
    logic              busy_nxt;
    logic              done_r;
    logic              done_nxt;
    logic              illegal_r;
    logic              illegal_nxt;
    logic [LEN_W-1:0]  len_r;
    logic [LEN_W-1:0]  len_nxt;
    logic [CNT_W-1:0]  states_r;
    logic [CNT_W-1:0]  states_nxt;
    logic [DATA_W-1:0] result_r;
    logic [DATA_W-1:0] result_nxt;
    logic [3:0]        flags_r;
    logic [3:0]        flags_nxt;
    logic              write_r;
    logic              write_nxt;

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    // Which operand forms each operation accepts
    function automatic logic form_ok(input aitl_op_e o,
                                     input aitl_form_e f,
                                     input logic [SHORT_W-1:0] s);
        logic acc_f;
        logic reg_f;
        logic step_f;
        logic sht_f;
        acc_f  = (f <= F_A_IMM);
        reg_f  = (f >= F_RR_B) && (f <= F_R_ATDR);
        step_f = (f >= F_INC_A) && (f <= F_INC_DATA_POINTER_REG);
        sht_f  = (f >= F_INC_R_SHT) && (f <= F_INC_D_SHT);
        case (o)
            OP_ADD:  return acc_f || (reg_f && f != F_D_IMM1);
            OP_SUB:  return reg_f && f != F_D_IMM1;
            OP_ADD_WITH_CARRY,
            OP_SUB_WITH_BORROW: return acc_f;
            OP_INC:  return step_f && !(sht_f && s > SHORT_CODE_4);
            OP_DEC:  return step_f && f != F_INC_DATA_POINTER_REG &&
                            !(sht_f && s > SHORT_CODE_4);
            OP_CMP:  return reg_f;
            default: return 1'b0;
        endcase
    endfunction

    // Operand width of a form
    function automatic aitl_wid_e form_wid(input aitl_form_e f);
        case (f)
            F_RR_W, F_W_IMM16, F_W_DIRECT_ADDR_8, F_W_DIRECT_ADDR_16,
            F_INC_W_SHT, F_INC_DATA_POINTER_REG:           return WID_W;
            F_RR_D, F_D_IMM0, F_D_IMM1,
            F_INC_D_SHT:                       return WID_D;
            default:                           return WID_B;
        endcase
    endfunction

    // Extra states for port, peripheral and external accesses
    function automatic logic [CNT_W-1:0] penalty(input aitl_form_e f,
                                                 input aitl_tgt_e t,
                                                 input logic [WAIT_W-1:0] n);
        logic [CNT_W-1:0] ext;
        ext = CNT_W'(n) + EXT_BASE;
        case (f)
            F_A_DIRECT_ADDR_8, F_R_DIRECT_ADDR_8: begin
                if (t == TGT_IO) begin
                    return PEN_IO_DIR;
                end
                return (t == TGT_SFR) ? PEN_SFR_DIR : CNT_ZERO;
            end
            F_INC_DIRECT_ADDR_8: begin
                if (t == TGT_IO) begin
                    return PEN_IO_INC;
                end
                return (t == TGT_SFR) ? PEN_SFR_INC : CNT_ZERO;
            end
            F_R_DIRECT_ADDR_16, F_R_ATWR, F_R_ATDR: begin
                return (t == TGT_EXT) ? ext : CNT_ZERO;
            end
            F_W_DIRECT_ADDR_16: begin
                return (t == TGT_EXT) ? (ext + ext) : CNT_ZERO;
            end
            default: return CNT_ZERO;
        endcase
    endfunction

    // Value of the short step constant
    function automatic logic [DATA_W-1:0] short_val(
        input logic [SHORT_W-1:0] s);
        case (s)
            SHORT_CODE_2: return VAL_TWO;
            SHORT_CODE_4: return VAL_FOUR;
            default:      return VAL_ONE;
        endcase
    endfunction

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    assign op    = aitl_op_e'(OP_I);
    assign form  = aitl_form_e'(FORM_I);
    assign tgt   = aitl_tgt_e'(TARGET_I);
    assign legal = form_ok(op, form, SHORT_I);

    // Length and base states from the form table
    always_comb begin
        cost    = aitl_base_cost(form);
        len_sel = SRC_MODE_I ? cost.src_len : cost.bin_len;
        total_st = CNT_W'(SRC_MODE_I ? cost.src_st : cost.bin_st);
        if (form == F_INC_D_SHT && op == OP_DEC) begin
            total_st = total_st + DEC_D_EXTRA;
        end
        total_st = total_st + penalty(form, tgt, WAIT_N_I);
    end

    // Source operand, with immediate extension
    always_comb begin
        case (form)
            F_A_IMM, F_R_IMM8: src_opnd = {24'h00_0000, SRC_I[7:0]};
            F_W_IMM16:         src_opnd = {HI_ZEROS, SRC_I[15:0]};
            F_D_IMM0:          src_opnd = {HI_ZEROS, SRC_I[15:0]};
            F_D_IMM1:          src_opnd = {HI_ONES, SRC_I[15:0]};
            F_INC_R_SHT, F_INC_W_SHT,
            F_INC_D_SHT:       src_opnd = short_val(SHORT_I);
            F_INC_A, F_INC_RN, F_INC_DIRECT_ADDR_8,
            F_INC_ATRI, F_INC_DATA_POINTER_REG: src_opnd = VAL_ONE;
            default:           src_opnd = SRC_I;
        endcase
    end

    // ----------------------------------------
    // Arithmetic unit
    // ----------------------------------------
    assign alu_bus.op   = op;
    assign alu_bus.wid  = form_wid(form);
    assign alu_bus.dest = DEST_I;
    assign alu_bus.src  = src_opnd;
    assign alu_bus.cin  = CARRY_I;

    aitl_alu u_alu (
        .bus (alu_bus.alu)
    );

    // ----------------------------------------
    // Execution sequencer
    // ----------------------------------------
    // Next state, state counter and captured results
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        busy_nxt    = busy_r;
        done_nxt    = 1'b0;
        illegal_nxt = illegal_r;
        len_nxt     = len_r;
        states_nxt  = states_r;
        result_nxt  = result_r;
        flags_nxt   = flags_r;
        write_nxt   = write_r;
        case (state_r)
            ST_IDLE: begin
                if (START_I && !legal) begin
                    done_nxt    = 1'b1;
                    illegal_nxt = 1'b1;
                    len_nxt     = '0;
                    states_nxt  = CNT_ZERO;
                    write_nxt   = 1'b0;
                end else if (START_I) begin
                    state_nxt   = ST_EXEC;
                    busy_nxt    = 1'b1;
                    cnt_nxt     = total_st;
                    illegal_nxt = 1'b0;
                    len_nxt     = len_sel;
                    states_nxt  = total_st;
                    result_nxt  = alu_bus.res;
                    flags_nxt   = {alu_bus.cout, alu_bus.zero,
                                   alu_bus.neg, alu_bus.ovf};
                    write_nxt   = alu_bus.wr;
                end
            end
            ST_EXEC: begin
                cnt_nxt = cnt_r - CNT_ONE;
                if (cnt_r <= CNT_ONE) begin
                    state_nxt = ST_IDLE;
                    busy_nxt  = 1'b0;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    // Sequencer and result registers
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r   <= ST_IDLE;
            cnt_r     <= CNT_ZERO;
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
            len_r     <= '0;
            states_r  <= CNT_ZERO;
            result_r  <= '0;
            flags_r   <= '0;
            write_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            busy_r    <= busy_nxt;
            done_r    <= done_nxt;
            illegal_r <= illegal_nxt;
            len_r     <= len_nxt;
            states_r  <= states_nxt;
            result_r  <= result_nxt;
            flags_r   <= flags_nxt;
            write_r   <= write_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign BUSY_O    = busy_r;
    assign DONE_O    = done_r;
    assign ILLEGAL_O = illegal_r;
    assign LEN_O     = len_r;
    assign STATES_O  = states_r;
    assign RESULT_O  = result_r;
    assign CARRY_O   = flags_r[3];
    assign ZERO_O    = flags_r[2];
    assign NEG_O     = flags_r[1];
    assign OVF_O     = flags_r[0];
    assign WRITE_O   = write_r;

endmodule

//--- testbench/aitl_core_sva.sv
`timescale 1ns/1ps
module aitl_core_sva
    import aitl_pkg::*;
(
    input logic               REF_CLK_I,
    input logic               RESET_N_I,
    input logic               START_I,
    input logic [OP_W-1:0]    OP_I,
    input logic [FORM_W-1:0]  FORM_I,
    input logic               SRC_MODE_I,
    input logic [TGT_W-1:0]   TARGET_I,
    input logic [WAIT_W-1:0]  WAIT_N_I,
    input logic [SHORT_W-1:0] SHORT_I,
    input logic               BUSY_O,
    input logic               DONE_O,
    input logic               ILLEGAL_O,
    input logic [LEN_W-1:0]   LEN_O,
    input logic [CNT_W-1:0]   STATES_O,
    input logic               WRITE_O
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             take;
    // Busy cycle count and accept strobe
    always_comb cnt_nxt = BUSY_O ? cnt_r + 8'h01 : 8'h00;
    assign take = START_I && !BUSY_O;
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) cnt_r <= 8'h00;
        else cnt_r <= cnt_nxt;
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Timing and cost relations
    chk_busy_span:
        assert property ($fell(BUSY_O) |-> DONE_O && cnt_r == STATES_O)
        else $error("busy span differs from states");
    chk_illegal_zero:
        assert property (ILLEGAL_O |-> !BUSY_O && LEN_O == 0 && STATES_O == 0)
        else $error("illegal request has cost");
    chk_cmp_no_write:
        assert property (take && OP_I == OP_CMP |=> !WRITE_O)
        else $error("compare writes destination");
    chk_rr_byte:
        assert property (take && OP_I == OP_ADD && FORM_I == F_RR_B &&
            SRC_MODE_I |=> LEN_O == 3'h2 && STATES_O == 8'h01)
        else $error("byte pair cost wrong");
    chk_io_direct_addr_8:
        assert property (take && OP_I == OP_ADD && FORM_I == F_A_DIRECT_ADDR_8 &&
            TARGET_I == TGT_IO |=> STATES_O == 8'h02 && BUSY_O ##2 DONE_O)
        else $error("port penalty wrong");
    chk_ext_word:
        assert property (take && OP_I == OP_CMP && FORM_I == F_W_DIRECT_ADDR_16 &&
            TARGET_I == TGT_EXT && !SRC_MODE_I
            |=> STATES_O == 8'h08 + {3'h0, $past(WAIT_N_I), 1'b0})
        else $error("word external penalty wrong");
    chk_short_bad:
        assert property (take && OP_I == OP_INC && FORM_I == F_INC_R_SHT &&
            SHORT_I == 2'h3 |=> ILLEGAL_O && DONE_O && !BUSY_O)
        else $error("bad short code taken");
    chk_dec_dword:
        assert property (take && OP_I == OP_DEC && FORM_I == F_INC_D_SHT &&
            SHORT_I != 2'h3 && SRC_MODE_I |=> STATES_O == 8'h04)
        else $error("dword decrement cost wrong");
endmodule
bind aitl_core aitl_core_sva u_sva (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .START_I(START_I),
    .OP_I(OP_I), .FORM_I(FORM_I), .SRC_MODE_I(SRC_MODE_I),
    .TARGET_I(TARGET_I), .WAIT_N_I(WAIT_N_I), .SHORT_I(SHORT_I),
    .BUSY_O(BUSY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O),
    .LEN_O(LEN_O), .STATES_O(STATES_O), .WRITE_O(WRITE_O));

//--- testbench/test_arith_instr_length_timing.sv
`timescale 1ns/1ps
module test_arith_instr_length_timing
    import aitl_pkg::*;
;
    logic               clk, rst_n, start, src_mode, cin, zf, nf;
    logic               busy, done, illegal, cy, wr;
    logic [OP_W-1:0]    op;
    logic [FORM_W-1:0]  form;
    logic [TGT_W-1:0]   tgt;
    logic [WAIT_W-1:0]  wait_n;
    logic [SHORT_W-1:0] short_c;
    logic [LEN_W-1:0]   len;
    logic [CNT_W-1:0]   states;
    logic [DATA_W-1:0]  dest, src, result;
    int                 error_cnt, comparisons, seed;
    // Per form: binary bytes, binary states, source bytes, source states
    localparam logic [15:0] COST [25] = '{
        16'h1122, 16'h2121, 16'h1223, 16'h2121, 16'h3221, 16'h3322, 16'h3524,
        16'h4332, 16'h5443, 16'h5645, 16'h5645, 16'h4332, 16'h4433, 16'h5342,
        16'h5443, 16'h4332, 16'h4433, 16'h1111, 16'h1122, 16'h2222, 16'h1324,
        16'h3221, 16'h3221, 16'h3423, 16'h1111};
    aitl_core u_dut (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .START_I(start), .OP_I(op),
        .FORM_I(form), .SRC_MODE_I(src_mode), .TARGET_I(tgt),
        .WAIT_N_I(wait_n), .SHORT_I(short_c), .CARRY_I(cin), .DEST_I(dest),
        .SRC_I(src), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(illegal),
        .LEN_O(len), .STATES_O(states), .RESULT_O(result), .CARRY_O(cy),
        .ZERO_O(zf), .NEG_O(nf), .OVF_O(), .WRITE_O(wr));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic int rnd(input int k);
        return {$random(seed)} % k;
    endfunction
    // Accepted operation and form pairs
    function automatic bit legal(input int o, f, s);
        if (f inside {[21:23]} && s == 3) return 1'b0;
        case (o)
            0, 1: return f inside {[o * 4:9], [11:16]};
            2, 3: return f <= 3;
            4, 5: return f inside {[17:28 - o]};
            6: return f inside {[4:16]};
            default: return 1'b0;
        endcase
    endfunction
    // One request, then its answer and busy span
    task automatic run(input int o, f, sm, t, n, s, c,
                       input logic [31:0] d, x);
        int          st, ln, w, j, k;
        logic [32:0] v, e, m;
        bit          ok;
        ok = legal(o, f, s);
        w = f inside {5, 8, 12, 14, 22} ? 16 : 8;
        if (f inside {6, 9, 10, 23}) w = 32;
        m = (33'h1 << w) - 33'h1;
        ln = ok ? (sm ? COST[f][7:4] : COST[f][15:12]) : 0;
        st = sm ? COST[f][3:0] : COST[f][11:8];
        if (f inside {1, 11} && t inside {1, 2}) st += t;
        if (f == 19 && t inside {1, 2}) st += t + 1;
        if (f inside {13, 15, 16} && t == 3) st += n + 2;
        if (f == 14 && t == 3) st += 2 * (n + 2);
        st = ok ? st + (o == 5 && f == 23) : 0;
        v = {1'b0, x};
        if (f == 9) v = {17'h0, x[15:0]};
        if (f == 10) v = {17'h0_FFFF, x[15:0]};
        if (o inside {4, 5}) v = f inside {[21:23]} ? 33'h1 << s : 33'h1;
        if (o inside {1, 3, 5, 6}) e = (d & m) - (v & m) - (o == 3 && c);
        else e = (d & m) + (v & m) + (o == 2 && c);
        @(posedge clk);
        start <= 1'b1;
        {op, form, src_mode, tgt, wait_n, short_c, cin, dest, src} <=
            {3'(o), 5'(f), sm[0], 2'(t), 4'(n), 2'(s), c[0], d, x};
        @(posedge clk);
        start <= 1'b0;
        #1;
        check("len", len, ln);
        check("states", states, st);
        check("illegal", illegal, !ok);
        check("write", wr, ok && o != 6);
        if (ok && f != 24) begin
            if (o != 6) check("result", result, e[31:0] & m[31:0]);
            check("carry", cy, e[w]);
            check("zero", zf, (e[31:0] & m[31:0]) == 0);
            check("neg", nf, e[w - 1]);
        end
        k = 0;
        for (j = 0; j < 300 && done !== 1'b1; j++) begin
            k += int'(busy === 1'b1);
            @(posedge clk);
            #1;
        end
        check("busy", k, st);
        check("done", done, 1);
    endtask
    // Reset, every form in both modes, corners, random requests
    initial begin
        seed = 88340;
        {rst_n, start, op, form, src_mode, tgt, wait_n, short_c, cin, dest,
            src} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int f = 0; f < 25; f++) begin
            for (int sm = 0; sm < 2; sm++) begin
                run(f > 16 ? 4 : f == 10 ? 6 : 0, f, sm, 0, 0, 0, 0,
                    $random(seed), $random(seed));
            end
        end
        run(2, 0, 0, 0, 0, 0, 1, 32'hFF, 32'h0);
        run(3, 3, 1, 0, 0, 0, 1, 32'h0, 32'h0);
        run(0, 1, 0, 1, 0, 0, 0, 32'h10, 32'h1);
        run(6, 14, 0, 3, 15, 0, 0, 32'h8000, 32'h8000);
        run(4, 21, 0, 0, 0, 3, 0, 32'h1, 32'h0);
        run(5, 23, 1, 0, 0, 2, 0, 32'h0, 32'h0);
        run(6, 10, 0, 0, 0, 0, 0, 32'h0, 32'h1);
        repeat (400) begin
            run(rnd(8), rnd(27), rnd(2), rnd(4), rnd(16), rnd(4), rnd(2),
                $random(seed), $random(seed));
        end
        complete_run();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
